// ### lcd_timing_defs.vh
// Purpose: Constants for the flat-panel horizontal total and line-delay register block
// Assumes: Indexed I/O port pair at 3?4 (index) / 3?5 (data), ? = B mono, D color
// Notes: Register contents have no reset value beyond a defined zero for simulation
// What this block does
// - Timing registers are reachable only while the panel extension unlock bit is one.
// - Data port decodes at 3B5 in monochrome mode and 3D5 in color mode.
// - Enable bit one makes 80-column byte and 40-column bits 6:0 the totals.
// - Enable bit zero only holds htotal_valid low; the selected total still reaches htotal_active.
// - 40-column total applies only when the clock divide bit is one.
// - 40-column total applies only when the shift register mode bit is zero.
// - Panel data is delayed by the selected scanline count from line frame start.
// - 480-line value is overflow bits 7:6 above its own 8-bit register.
// - 480-line value is selected when the vertical line mode field is 11.
// - 350-line value is overflow bits 5:4 above its own 8-bit register.
// - 350-line value is selected for mode 10 with automatic centering set.
// - 400-line value is overflow bits 3:2 above its own 8-bit register.
// - 400-line value is selected for mode 01 with automatic centering set.
// - 80-column total applies when clock divide is zero or shift mode is one.
// - Mode 00 uses a fourth value, the whole 10-bit vdelay_cmp_default input.
`ifndef LCD_TIMING_DEFS_VH
`define LCD_TIMING_DEFS_VH
`define IO_ADDR_DATA_MONO   16'h03b5
`define IO_ADDR_DATA_COLOR  16'h03d5
`define IO_ADDR_INDEX_MONO  16'h03b4
`define IO_ADDR_INDEX_COLOR 16'h03d4
`define IDX_HTOTAL_40COL    8'h01
`define IDX_VDELAY_CMP_480  8'h02
`define IDX_VDELAY_CMP_350  8'h03
`define IDX_VDELAY_CMP_400  8'h04
`define HT_EN_BIT           7
`define HT40_MSB            6
`define NUM_TIMING_REGS     4
`define SLOT_HTOTAL_40COL   2'h0
`define SLOT_VDELAY_480     2'h1
`define SLOT_VDELAY_350     2'h2
`define SLOT_VDELAY_400     2'h3
`define OVF_480_HI          7
`define OVF_480_LO          6
`define OVF_350_HI          5
`define OVF_350_LO          4
`define OVF_400_HI          3
`define OVF_400_LO          2
`define VMODE_480           2'h3
`define VMODE_350           2'h2
`define VMODE_400           2'h1
`define VMODE_DEFAULT       2'h0
`define REG_RESET           8'h00
`define CNT_RESET           10'h000
`define CNT_ONE             10'h001
`endif

// ### lcd_htotal_vdelay_regs.v
// Purpose: Indexed register block for 40-column total and three line-delay compare values
// Assumes: I/O strobes are one-cycle pulses synchronous to core_clk; panel inputs from core_clk logic
// Notes: Index register is shared with the rest of the controller and shadowed here
`timescale 1ns/1ps
`default_nettype none
`include "lcd_timing_defs.vh"
module lcd_htotal_vdelay_regs (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [15:0] io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [7:0]  io_wdata,
  input  wire        color_mode,
  input  wire        panel_ext_unlock,
  input  wire        auto_center,
  input  wire [1:0]  vline_mode,
  input  wire        clk_div2,
  input  wire        shift_mode_256,
  input  wire [7:0]  htotal_80col,
  input  wire [7:0]  vdelay_cmp_overflow,
  input  wire [9:0]  vdelay_cmp_default,
  input  wire        line_frame_start,
  input  wire        scanline_tick,
  output reg  [7:0]  io_rdata,
  output reg         io_rdata_valid,
  output reg         htotal_valid,
  output reg  [7:0]  htotal_active,
  output reg  [9:0]  vdelay_active,
  output reg         panel_data_release
);

  // Slot numbers are the register indexes less one
  localparam NUM_REGS = `NUM_TIMING_REGS;

  // Host-visible state
  reg  [7:0]          index_r;
  reg  [7:0]          regs_r [0:NUM_REGS-1];

  // Line delay counter
  reg  [9:0]          line_cnt_r;
  reg  [9:0]          line_cnt_nxt;

  // Next values of the registered outputs
  reg  [7:0]          rdata_nxt;
  reg                 rvalid_nxt;
  reg  [7:0]          htotal_nxt;
  reg  [9:0]          vdelay_nxt;
  reg                 release_nxt;

  // Decode
  wire                data_hit;
  wire                index_hit;
  wire                reg_hit;
  wire [NUM_REGS-1:0] slot_wr;

  // Register views
  wire [7:0]          htotal_40col;
  wire                htotal_en;
  wire [9:0]          cmp_480_full;
  wire [9:0]          cmp_350_full;
  wire [9:0]          cmp_400_full;
  wire                use_40col;
  integer             n;

  // True for the indexes that this block answers
  function is_mine;
    input [7:0] idx;
    begin
      is_mine = (idx == `IDX_HTOTAL_40COL) || (idx == `IDX_VDELAY_CMP_480) ||
                (idx == `IDX_VDELAY_CMP_350) || (idx == `IDX_VDELAY_CMP_400);
    end
  endfunction

  // Storage slot of an index; callers qualify it with is_mine
  function [1:0] slot_of;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_HTOTAL_40COL:   slot_of = `SLOT_HTOTAL_40COL;
        `IDX_VDELAY_CMP_480: slot_of = `SLOT_VDELAY_480;
        `IDX_VDELAY_CMP_350: slot_of = `SLOT_VDELAY_350;
        `IDX_VDELAY_CMP_400: slot_of = `SLOT_VDELAY_400;
        default:             slot_of = `SLOT_HTOTAL_40COL;
      endcase
    end
  endfunction

  // Port decode follows the mono/color select
  assign data_hit  = io_addr == (color_mode ? `IO_ADDR_DATA_COLOR : `IO_ADDR_DATA_MONO);
  assign index_hit = io_addr == (color_mode ? `IO_ADDR_INDEX_COLOR : `IO_ADDR_INDEX_MONO);
  assign reg_hit   = data_hit && panel_ext_unlock && is_mine(index_r);

  // Index shadow: the host writes it before each data access
  always @(posedge core_clk) begin
    if (srst)
      index_r <= `REG_RESET;
    else if (io_wr && index_hit)
      index_r <= io_wdata;
  end

  // One write enable per slot
  genvar k;
  generate
    for (k = 0; k < NUM_REGS; k = k + 1) begin : g_slot_wr
      localparam integer SLOT_ID = k;
      assign slot_wr[k] = io_wr && reg_hit && (slot_of(index_r) == SLOT_ID[1:0]);
    end
  endgenerate

  // Register file; the same bits always feed the timing outputs, the enable bit sets only htotal_valid
  always @(posedge core_clk) begin
    if (srst) begin
      for (n = 0; n < NUM_REGS; n = n + 1) begin
        regs_r[n] <= `REG_RESET;
      end
    end else begin
      for (n = 0; n < NUM_REGS; n = n + 1) begin
        if (slot_wr[n])
          regs_r[n] <= io_wdata;
      end
    end
  end

  // Read path; a locked or foreign index returns zero with no valid pulse
  always @* begin
    rvalid_nxt = io_rd && reg_hit;
    if (rvalid_nxt)
      rdata_nxt = regs_r[slot_of(index_r)];
    else
      rdata_nxt = `REG_RESET;
  end

  // Views of the stored registers
  assign htotal_40col = regs_r[`SLOT_HTOTAL_40COL];
  assign htotal_en    = htotal_40col[`HT_EN_BIT];
  assign cmp_480_full = {vdelay_cmp_overflow[`OVF_480_HI:`OVF_480_LO], regs_r[`SLOT_VDELAY_480]};
  assign cmp_350_full = {vdelay_cmp_overflow[`OVF_350_HI:`OVF_350_LO], regs_r[`SLOT_VDELAY_350]};
  assign cmp_400_full = {vdelay_cmp_overflow[`OVF_400_HI:`OVF_400_LO], regs_r[`SLOT_VDELAY_400]};

  // The 40-column total needs the divided dot clock and the planar shift mode
  assign use_40col = clk_div2 && !shift_mode_256;

  // Horizontal total selection
  always @* begin
    if (use_40col)
      htotal_nxt = {1'b0, htotal_40col[`HT40_MSB:0]};
    else
      htotal_nxt = htotal_80col;
  end

  // Line-delay compare selection; centered modes without centering fall back to 480
  always @* begin
    case (vline_mode)
      `VMODE_480: vdelay_nxt = cmp_480_full;
      `VMODE_350: begin
        if (auto_center)
          vdelay_nxt = cmp_350_full;
        else
          vdelay_nxt = cmp_480_full;
      end
      `VMODE_400: begin
        if (auto_center)
          vdelay_nxt = cmp_400_full;
        else
          vdelay_nxt = cmp_480_full;
      end
      default:    vdelay_nxt = vdelay_cmp_default;
    endcase
  end

  // Scanline counter: cleared by frame start, stops at the compare value
  always @* begin
    if (line_frame_start)
      line_cnt_nxt = `CNT_RESET;
    else if (scanline_tick && line_cnt_r != vdelay_active)
      line_cnt_nxt = line_cnt_r + `CNT_ONE;
    else
      line_cnt_nxt = line_cnt_r;
  end

  // Release once the count meets the selected value; never in a frame start cycle
  always @* begin
    release_nxt = !line_frame_start && (line_cnt_nxt == vdelay_nxt);
  end

  always @(posedge core_clk) begin
    if (srst)
      line_cnt_r <= `CNT_RESET;
    else
      line_cnt_r <= line_cnt_nxt;
  end

  // Host read answer, one cycle after the strobe
  always @(posedge core_clk) begin
    if (srst) begin
      io_rdata       <= `REG_RESET;
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata       <= rdata_nxt;
      io_rdata_valid <= rvalid_nxt;
    end
  end

  // Panel timing outputs, one cycle behind their selects
  always @(posedge core_clk) begin
    if (srst) begin
      htotal_valid       <= 1'b0;
      htotal_active      <= `REG_RESET;
      vdelay_active      <= `CNT_RESET;
      panel_data_release <= 1'b0;
    end else begin
      htotal_valid       <= htotal_en;
      htotal_active      <= htotal_nxt;
      vdelay_active      <= vdelay_nxt;
      panel_data_release <= release_nxt;
    end
  end

  // Reset values are a simulation convenience; software programs every register
endmodule // lcd_htotal_vdelay_regs
`default_nettype wire

// ### lcd_regs_chk_properties.sv
// Purpose: Port checker for the timing register block
// Assumes: One clock, sync reset
// Notes: Outputs lag their causes by one cycle
`timescale 1ns/1ps
`default_nettype none
module lcd_regs_chk (
  input wire logic core_clk, srst, io_rd, color_mode, panel_ext_unlock, auto_center, clk_div2, shift_mode_256,
  input wire logic line_frame_start, io_rdata_valid, panel_data_release,
  input wire logic [15:0] io_addr,
  input wire logic [1:0] vline_mode,
  input wire logic [7:0] htotal_80col, vdelay_cmp_overflow, htotal_active,
  input wire logic [9:0] vdelay_cmp_default, vdelay_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_read_unlocked: assert property (io_rdata_valid |-> $past(io_rd) && $past(panel_ext_unlock))
    else $error("locked read");
  a_data_port: assert property (io_rd && io_addr != {8'h03, color_mode ? 8'hd5 : 8'hb5} |=>
    !io_rdata_valid) else $error("port");
  a_ht_40col: assert property (clk_div2 && !shift_mode_256 |=> !htotal_active[7]) else $error("ht40");
  a_ht_80col: assert property (!clk_div2 || shift_mode_256 |=>
    htotal_active == $past(htotal_80col)) else $error("ht80");
  a_vd_480: assert property (vline_mode == 2'h3 |=>
    vdelay_active[9:8] == $past(vdelay_cmp_overflow[7:6])) else $error("v480");
  a_vd_350: assert property (vline_mode == 2'h2 && auto_center |=>
    vdelay_active[9:8] == $past(vdelay_cmp_overflow[5:4])) else $error("v350");
  a_vd_400: assert property (vline_mode == 2'h1 && auto_center |=>
    vdelay_active[9:8] == $past(vdelay_cmp_overflow[3:2])) else $error("v400");
  a_vd_default: assert property (vline_mode == 2'h0 |=>
    vdelay_active == $past(vdelay_cmp_default)) else $error("vdef");
  a_lfs_holds: assert property (line_frame_start |=> !panel_data_release) else $error("lfs");
endmodule // lcd_regs_chk
bind lcd_htotal_vdelay_regs lcd_regs_chk chk_u (.core_clk(core_clk), .srst(srst), .io_rd(io_rd),
  .color_mode(color_mode), .panel_ext_unlock(panel_ext_unlock), .auto_center(auto_center),
  .clk_div2(clk_div2), .shift_mode_256(shift_mode_256), .line_frame_start(line_frame_start),
  .io_rdata_valid(io_rdata_valid), .panel_data_release(panel_data_release), .io_addr(io_addr),
  .vline_mode(vline_mode), .htotal_80col(htotal_80col), .vdelay_cmp_overflow(vdelay_cmp_overflow),
  .htotal_active(htotal_active), .vdelay_cmp_default(vdelay_cmp_default), .vdelay_active(vdelay_active));
`default_nettype wire

// ### lcd_htotal_vdelay_regs_tb_top.sv
// Purpose: Directed bench for the timing register block
// Assumes: Index port one below the data port
// Notes: Level outputs sampled three cycles after a change
`timescale 1ns/1ps
`default_nettype none
module lcd_htotal_vdelay_regs_tb_top;
  logic core_clk, srst, io_wr, io_rd, color_mode, panel_ext_unlock, auto_center, clk_div2, shift_mode_256;
  logic line_frame_start, scanline_tick, io_rdata_valid, htotal_valid, panel_data_release;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, htotal_80col, vdelay_cmp_overflow, io_rdata, htotal_active;
  logic [9:0] vdelay_cmp_default, vdelay_active;
  logic [1:0] vline_mode;
  int miscompares, compares, cyc, i;
  lcd_htotal_vdelay_regs dut_u (.*);
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 600) tally_and_finish;
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    compares++;
    miscompares += (g !== e);
    if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
  endtask
  task automatic tally_and_finish;
    miscompares += (cyc > 600);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, x, input logic w, input logic [7:0] d, input logic v);
    @(posedge core_clk) {io_wr, io_addr, io_wdata} <= {9'h103, a - 8'h01, x};
    @(posedge core_clk) {io_wr, io_rd, io_addr, io_wdata} <= {w, !w, 8'h03, a, d};
    @(posedge core_clk) {io_wr, io_rd} <= 2'b00;
    #1 chk("vld", v, io_rdata_valid);
    chk("rd", v ? d : 8'h00, io_rdata);
  endtask
  task automatic ht(input logic [1:0] m, input logic [9:0] e);
    @(posedge core_clk) {clk_div2, shift_mode_256} <= m;
    repeat (3) @(posedge core_clk);
    #1 chk("ht", e, htotal_active);
  endtask
  initial begin
    core_clk = 1'b0;
    {srst, color_mode, panel_ext_unlock, clk_div2, io_wr, io_rd, auto_center, shift_mode_256} = 8'hf0;
    {line_frame_start, scanline_tick, io_addr, io_wdata, vline_mode} = 28'h0;
    {htotal_80col, vdelay_cmp_overflow, vdelay_cmp_default} = {8'h9c, 8'he4, 10'h003};
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (i = 1; i < 5; i++) acc(8'hd5, i[7:0], 1'b1, 8'h40 + i[7:0], 1'b0);
    for (i = 1; i < 5; i++) acc(8'hd5, i[7:0], 1'b0, 8'h40 + i[7:0], 1'b1);
    chk("htv", 10'h000, htotal_valid);
    @(posedge core_clk) panel_ext_unlock <= 1'b0;
    acc(8'hd5, 8'h02, 1'b1, 8'haa, 1'b0);
    acc(8'hd5, 8'h02, 1'b0, 8'h00, 1'b0);
    @(posedge core_clk) panel_ext_unlock <= 1'b1;
    acc(8'hd5, 8'h02, 1'b0, 8'h42, 1'b1);
    acc(8'hb5, 8'h02, 1'b0, 8'h00, 1'b0);
    @(posedge core_clk) color_mode <= 1'b0;
    acc(8'hb5, 8'h01, 1'b1, 8'hc5, 1'b0);
    ht(2'b10, 10'h045);
    chk("htv", 10'h001, htotal_valid);
    ht(2'b11, 10'h09c);
    ht(2'b00, 10'h09c);
    @(posedge core_clk) auto_center <= 1'b1;
    for (i = 1; i < 5; i++) begin
      @(posedge core_clk) vline_mode <= 2'(4 - i);
      repeat (3) @(posedge core_clk);
      #1 chk("vd", (i == 4) ? 10'h003 : {2'(4 - i), 8'h41 + 8'(i)}, vdelay_active);
    end
    @(posedge core_clk) line_frame_start <= 1'b1;
    @(posedge core_clk) {line_frame_start, scanline_tick} <= 2'b01;
    repeat (2) @(posedge core_clk);
    #1 chk("rel", 10'h000, panel_data_release);
    @(posedge core_clk) scanline_tick <= 1'b0;
    #1 chk("rel", 10'h001, panel_data_release);
    tally_and_finish;
  end
endmodule // lcd_htotal_vdelay_regs_tb_top
`default_nettype wire
